//--- src/rstu_top.sv
// Reset unit: source combining, pin filter, init timer, cause flags, APB slave
//
// Decided for this implementation: the APB slave port.
`include "rstu_defs.svh"

module rstu_top #(
  parameter int unsigned SUT_UNIT_CYC = `RSTU_SUT_UNIT_CYC,
  parameter int unsigned SCAN_CYC = `RSTU_SCAN_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic por_req_i,
  input wire logic bod_req_i,
  input wire logic bod_level_ok_i,
  input wire logic rst_pin_n_i,
  input wire logic reset_pin_select_i,
  input wire logic wdt_timeout_i,
  input wire logic dbg_rst_req_i,
  input wire logic [2:0] startup_delay_select_i,
  input wire logic [1:0] memory_scan_source_i,
  output logic sys_rst_n_o,
  output logic fuse_reload_o,
  output logic bod_cfg_rst_n_o,
  output logic dbg_port_rst_n_o
);

  // ****************************************
  // Declarations
  // ****************************************
  rstu_pkg::rstu_state_e state_reg;
  rstu_pkg::rstu_src_s flags_reg;
  rstu_pkg::rstu_src_s flags_next;
  rstu_pkg::rstu_src_s src;
  logic bod_hold_reg;
  logic [15:0] filt_cnt_reg;
  logic pin_req_reg;
  logic sw_req_reg;
  logic [2:0] unlock_reg;
  logic [31:0] init_cnt_reg;
  logic [31:0] init_load;
  logic [31:0] prdata_reg;
  logic fuse_reload_reg;
  logic any_req;
  logic xfer_done;
  logic wr_done;
  logic addr_ok;
  logic [5:0] idx;

  // ****************************************
  // APB decode
  // ****************************************
  assign idx = paddr_i[7:2];
  assign addr_ok = (paddr_i[1:0] == 2'h0) &&
    (idx == `RSTU_IDX_FLAGS || idx == `RSTU_IDX_SWREQ || idx == `RSTU_IDX_KEY);
  assign xfer_done = psel_i && penable_i;
  assign wr_done = xfer_done && pwrite_i && addr_ok;
  assign pready_o = psel_i && penable_i;
  assign pslverr_o = xfer_done && !addr_ok;
  assign prdata_o = prdata_reg;

  // Read data captured in the setup phase
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      prdata_reg <= 32'h0;
    else if (ce_i && psel_i && !penable_i)
    begin
      if (idx == `RSTU_IDX_FLAGS && paddr_i[1:0] == 2'h0)
        prdata_reg <= {26'h0, flags_reg};
      else
        prdata_reg <= 32'h0;
    end
  end

  // ****************************************
  // Change protection window
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      unlock_reg <= 3'h0;
    else if (ce_i && xfer_done)
    begin
      if (wr_done && idx == `RSTU_IDX_KEY && pwdata_i[7:0] == `RSTU_KEY_IO_REGISTER_KEY)
        unlock_reg <= `RSTU_UNLOCK_XFERS;
      else if (unlock_reg != 3'h0)
        unlock_reg <= unlock_reg - 3'h1;
    end
  end

  // Soft reset trigger, a one-cycle request
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sw_req_reg <= 1'b0;
    else if (ce_i)
      sw_req_reg <= wr_done && idx == `RSTU_IDX_SWREQ && unlock_reg != 3'h0 &&
        pwdata_i[`RSTU_SOFT_RESET_TRIGGER_BIT];
  end

  // ****************************************
  // Brown-out hold
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bod_hold_reg <= 1'b0;
    else if (ce_i)
    begin
      if (bod_req_i)
        bod_hold_reg <= 1'b1;
      else if (bod_level_ok_i)
        bod_hold_reg <= 1'b0;
    end
  end

  // ****************************************
  // Reset pin filter
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      filt_cnt_reg <= 16'h0;
      pin_req_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!reset_pin_select_i || rst_pin_n_i)
      begin
        filt_cnt_reg <= 16'h0;
        pin_req_reg <= 1'b0;
      end
      else if (filt_cnt_reg == 16'(`RSTU_PIN_FILT_CYC - 1))
        pin_req_reg <= 1'b1;
      else
        filt_cnt_reg <= filt_cnt_reg + 16'h1;
    end
  end

  // ****************************************
  // Source combining
  // ****************************************
  always_comb
  begin
    src.por = por_req_i;
    src.bor = bod_req_i || bod_hold_reg;
    src.pin = pin_req_reg;
    src.wdt = wdt_timeout_i;
    src.sw = sw_req_reg;
    src.dbg = dbg_rst_req_i;
  end

  assign any_req = |src;

  // Initial count: base, start-up delay, optional memory scan
  assign init_load = 32'(`RSTU_INIT_CYC) +
    32'(startup_delay_select_i) * SUT_UNIT_CYC +
    ((memory_scan_source_i != `RSTU_SCAN_OFF) ? SCAN_CYC : 32'h0);

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= rstu_pkg::RSTU_HOLD;
      init_cnt_reg <= 32'h0;
    end
    else if (ce_i)
    begin
      if (any_req)
        state_reg <= rstu_pkg::RSTU_HOLD;
      else
      begin
        unique case (state_reg)
          rstu_pkg::RSTU_HOLD:
          begin
            state_reg <= rstu_pkg::RSTU_INIT;
            init_cnt_reg <= init_load;
          end
          rstu_pkg::RSTU_INIT:
          begin
            if (init_cnt_reg <= 32'h1)
              state_reg <= rstu_pkg::RSTU_RUN;
            else
              init_cnt_reg <= init_cnt_reg - 32'h1;
          end
          rstu_pkg::RSTU_RUN:
            state_reg <= rstu_pkg::RSTU_RUN;
        endcase
      end
    end
  end

  // Fuse reload pulse on entry to initialization
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      fuse_reload_reg <= 1'b0;
    else if (ce_i)
      fuse_reload_reg <= !any_req && state_reg == rstu_pkg::RSTU_HOLD;
  end

  assign fuse_reload_o = fuse_reload_reg;
  // Assert path is combinational from the requests, release from the sequencer
  assign sys_rst_n_o = (state_reg == rstu_pkg::RSTU_RUN) && !any_req;
  assign bod_cfg_rst_n_o = !src.por;
  assign dbg_port_rst_n_o = !(src.por || src.bor);

  // ****************************************
  // Cause flags
  // ****************************************
  always_comb
  begin
    flags_next = flags_reg;
    if (wr_done && idx == `RSTU_IDX_FLAGS)
      flags_next = flags_reg & ~pwdata_i[`RSTU_FLG_W-1:0];
    if (src.por)
      flags_next = 6'h01;
    else if (src.bor)
      flags_next = {4'h0, 1'b1, flags_next.por};
    else
      flags_next = flags_next | src;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      flags_reg <= 6'h0;
    else if (ce_i)
      flags_reg <= flags_next;
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_sw_needs_key: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ce_i && wr_done && idx == `RSTU_IDX_SWREQ && unlock_reg == 3'h0 |=> !sw_req_reg)
    else $error("soft reset taken without unlock");

  a_sw_immediate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ce_i && wr_done && idx == `RSTU_IDX_SWREQ && unlock_reg != 3'h0 && pwdata_i[`RSTU_SOFT_RESET_TRIGGER_BIT]
    |=> !sys_rst_n_o && sw_req_reg ##1 (flags_reg.sw || flags_reg.por || flags_reg.bor))
    else $error("soft reset not started at once");

  a_pin_filter: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(pin_req_reg) |-> $past(filt_cnt_reg) == 16'(`RSTU_PIN_FILT_CYC - 1))
    else $error("pin request before filter time");

  a_pin_disabled: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !reset_pin_select_i && ce_i |=> !pin_req_reg)
    else $error("pin request while pin disabled");

  a_pin_holds: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    pin_req_reg && !rst_pin_n_i && reset_pin_select_i |-> !sys_rst_n_o)
    else $error("released while pin low");

  a_bod_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    bod_hold_reg && !bod_level_ok_i |-> !sys_rst_n_o ##1 !sys_rst_n_o)
    else $error("released before supply recovered");

  a_wdt_reset: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wdt_timeout_i |-> !sys_rst_n_o ##1 (state_reg != rstu_pkg::RSTU_RUN))
    else $error("watchdog did not reset");

  a_init_len: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ce_i && !any_req && state_reg == rstu_pkg::RSTU_HOLD
    |=> state_reg == rstu_pkg::RSTU_INIT && init_cnt_reg == $past(init_load))
    else $error("init phase count wrong");

  a_por_flags: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    por_req_i && ce_i |=> flags_reg == 6'h01)
    else $error("power-on flags wrong");

  a_bor_flags: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    bod_req_i && !por_req_i && ce_i |=> flags_reg[5:1] == 5'h01)
    else $error("brown-out flags wrong");

  a_w1c_flags: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ce_i && wr_done && idx == `RSTU_IDX_FLAGS && !any_req
    |=> flags_reg == ($past(flags_reg) & ~$past(pwdata_i[`RSTU_FLG_W-1:0])))
    else $error("write-one-to-clear wrong");

  a_domains: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !bod_cfg_rst_n_o |-> !dbg_port_rst_n_o && !sys_rst_n_o)
    else $error("reset domains out of order");

  a_swreq_reads_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ce_i && psel_i && !penable_i && idx == `RSTU_IDX_SWREQ |=> prdata_o == 32'h0)
    else $error("trigger bit read nonzero");

  c_pin_reset: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(pin_req_reg));
  c_sw_reset: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(sw_req_reg));
  c_release: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(sys_rst_n_o));
  c_bod_reset: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(bod_hold_reg));

endmodule // rstu_top

//--- src/rstu_defs.svh
// Register map, field positions and timing constants of the reset unit
`ifndef RSTU_DEFS_SVH
`define RSTU_DEFS_SVH

// ****************************************
// Register indices, byte address is four times the index
// ****************************************
`define RSTU_IDX_FLAGS 6'h00
`define RSTU_IDX_SWREQ 6'h01
`define RSTU_IDX_KEY 6'h02
`define RSTU_KEY_IO_REGISTER_KEY 8'h5a
`define RSTU_UNLOCK_XFERS 3'h4

// ****************************************
// Field positions
// ****************************************
`define RSTU_FLG_POR 0
`define RSTU_FLG_BOR 1
`define RSTU_FLG_PIN 2
`define RSTU_FLG_WDT 3
`define RSTU_FLG_SW 4
`define RSTU_FLG_DBG 5
`define RSTU_FLG_W 6
`define RSTU_SOFT_RESET_TRIGGER_BIT 0
`define RSTU_SCAN_OFF 2'h3

// ****************************************
// Timing
// ****************************************
`define RSTU_CLK_PERIOD_NS 4
`define RSTU_PIN_FILT_NS 2000
`define RSTU_PIN_FILT_CYC ((`RSTU_PIN_FILT_NS + `RSTU_CLK_PERIOD_NS - 1) / `RSTU_CLK_PERIOD_NS)
`define RSTU_INIT_NS 64
`define RSTU_INIT_CYC ((`RSTU_INIT_NS + `RSTU_CLK_PERIOD_NS - 1) / `RSTU_CLK_PERIOD_NS)
`define RSTU_SUT_UNIT_NS 1000000
`define RSTU_SUT_UNIT_CYC ((`RSTU_SUT_UNIT_NS + `RSTU_CLK_PERIOD_NS - 1) / `RSTU_CLK_PERIOD_NS)
`define RSTU_SCAN_NS 100000
`define RSTU_SCAN_CYC ((`RSTU_SCAN_NS + `RSTU_CLK_PERIOD_NS - 1) / `RSTU_CLK_PERIOD_NS)

`endif

//--- src/rstu_pkg.sv
// Types of the reset unit
package rstu_pkg;

  typedef enum logic [1:0] {
    RSTU_HOLD,
    RSTU_INIT,
    RSTU_RUN
  } rstu_state_e;

  typedef struct packed {
    logic dbg;
    logic sw;
    logic wdt;
    logic pin;
    logic bor;
    logic por;
  } rstu_src_s;

endpackage

//--- dv/rstu_src_model.sv
// Behavioural model of the reset request sources and the reset pin
module rstu_src_model (
  input wire logic sys_clk_i,
  input wire logic [5:0] fire_i,
  input wire logic [10:0] len_i,
  output rstu_pkg::rstu_src_s req_o,
  output logic bod_level_ok_o,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] cnt_reg = 11'h000;
  logic [5:0] src_reg = 6'h00;
  always_ff @(posedge sys_clk_i)
  begin
    if (fire_i != 6'h00)
    begin
      cnt_reg <= len_i;
      src_reg <= fire_i;
    end
    else if (cnt_reg != 11'h000)
      cnt_reg <= cnt_reg - 11'h001;
  end
  assign busy_o = (cnt_reg != 11'h000);
  // Request level held for the commanded length
  assign req_o = busy_o ? rstu_pkg::rstu_src_s'(src_reg) : '0;
  // Supply back above threshold once the brown-out ends
  assign bod_level_ok_o = !(busy_o && src_reg[1]);
endmodule // rstu_src_model

//--- dv/testbench.sv
// Self-checking bench of the reset unit
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SUT_U = 4;
  localparam int SCAN_U = 3;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sys_rst_n, fuse_reload, bod_cfg_n, dbg_n, lvl_ok, busy, err;
  logic pin_sel = 1'b1;
  logic [2:0] startup_delay_select = 3'h0;
  logic [1:0] scan = 2'h3;
  logic [5:0] fire = 6'h00;
  logic [10:0] len = 11'h000;
  logic [31:0] rd;
  rstu_pkg::rstu_src_s req;
  int err_total = 0;
  int n_compared = 0;
  int flags = 0;
  int cyc = 0;
  integer seed = 32'h44a4;

  always #2 sys_clk_i = ~sys_clk_i;

  rstu_top #(.SUT_UNIT_CYC(SUT_U), .SCAN_CYC(SCAN_U)) u_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .por_req_i(req.por),
    .bod_req_i(req.bor), .bod_level_ok_i(lvl_ok), .rst_pin_n_i(!req.pin),
    .reset_pin_select_i(pin_sel), .wdt_timeout_i(req.wdt), .dbg_rst_req_i(req.dbg),
    .startup_delay_select_i(startup_delay_select), .memory_scan_source_i(scan), .sys_rst_n_o(sys_rst_n),
    .fuse_reload_o(fuse_reload), .bod_cfg_rst_n_o(bod_cfg_n), .dbg_port_rst_n_o(dbg_n));

  rstu_src_model u_src (.sys_clk_i(sys_clk_i), .fire_i(fire), .len_i(len), .req_o(req),
    .bod_level_ok_o(lvl_ok), .busy_o(busy));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_total++;
      wrap_up();
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do
      @(posedge sys_clk_i);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_run(input bit timed, input int extra);
    int n;
    int pulses;
    int exp_n;
    n = 0;
    pulses = 0;
    do @(negedge sys_clk_i); while (busy === 1'b1);
    check("held in reset", sys_rst_n, 1'b0);
    while (sys_rst_n !== 1'b1 && n < 3000)
    begin
      @(negedge sys_clk_i);
      n++;
      if (fuse_reload === 1'b1)
        pulses++;
    end
    check("released", sys_rst_n, 1'b1);
    // Brown-out hold register keeps reset one cycle past the request
    exp_n = 17 + startup_delay_select * SUT_U + extra;
    if (scan != 2'h3)
      exp_n = exp_n + SCAN_U;
    if (timed)
      check("init length", n, exp_n);
    check("fuse reload pulses", pulses, 1);
  endtask

  task automatic run_src(input logic [5:0] f, input int l, input bit hits);
    @(posedge sys_clk_i);
    startup_delay_select <= 3'($random(seed));
    scan <= 2'($random(seed));
    fire <= f;
    len <= 11'(l);
    @(posedge sys_clk_i);
    fire <= 6'h00;
    @(negedge sys_clk_i);
    if (f[2] == 1'b0)
    begin
      check("reset low", sys_rst_n, 1'b0);
      check("bod cfg reset", bod_cfg_n, !f[0]);
      check("debug port reset", dbg_n, !(f[0] | f[1]));
    end
    if (hits)
    begin
      flags = f[0] ? 1 : f[1] ? ((flags & 1) | 2) : (flags | f);
      wait_run(f[2] == 1'b0, int'(f[1]));
    end
    else
      repeat (l + 2)
      begin
        @(negedge sys_clk_i);
        check("reset held off", sys_rst_n, 1'b1);
      end
    apb(1'b0, 8'h00, 32'h0);
    check("cause flags", rd, 32'(flags));
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    wait_run(1'b1, 0);
    run_src(6'h01, 20, 1'b1);
    run_src(6'h08, 3, 1'b1);
    run_src(6'h20, 5, 1'b1);
    run_src(6'h04, 100, 1'b0);
    run_src(6'h04, 600, 1'b1);
    @(posedge sys_clk_i);
    pin_sel <= 1'b0;
    run_src(6'h04, 600, 1'b0);
    pwdata <= 32'($random(seed)) & 32'h3f;
    @(posedge sys_clk_i);
    flags = flags & ~int'(pwdata);
    apb(1'b1, 8'h00, pwdata);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    check("flags after clear", rd, 32'(flags));
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b1, 8'h08, 32'h5a);
    repeat (4) apb(1'b0, 8'h00, 32'h0);
    apb(1'b1, 8'h04, 32'h1);
    repeat (3) @(negedge sys_clk_i);
    check("locked soft reset", sys_rst_n, 1'b1);
    apb(1'b0, 8'h04, 32'h0);
    check("trigger reads zero", rd, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    check("unmapped error", err, 1'b1);
    apb(1'b1, 8'h08, 32'h5a);
    apb(1'b1, 8'h04, 32'h1);
    @(negedge sys_clk_i);
    check("soft reset", sys_rst_n, 1'b0);
    flags = flags | 32'h10;
    wait_run(1'b0, 0);
    apb(1'b0, 8'h00, 32'h0);
    check("soft flag", rd, 32'(flags));
    run_src(6'h02, 10, 1'b1);
    wrap_up();
  end
endmodule // testbench
